// ---- eiocb_pkg.sv ----
package eiocb_pkg;
	// word offsets within the register slot (byte address = 4 * index)
	localparam logic [7:0] REG_ID = 8'h01;
	localparam logic [7:0] REG_ICS = 8'h03;
	localparam logic [7:0] REG_EXTID = 8'h05;
	localparam logic [7:0] REG_PTR = 8'h08;
	localparam logic [7:0] REG_CTRL = 8'h10;
	localparam logic [7:0] REG_DATA = 8'h11;
	localparam logic [7:0] REG_DMA = 8'h12;
	localparam logic [7:0] REG_UID = 8'h65;
	// identity values are arbitrary
	localparam logic [7:0] ID_RESET = 8'h5a;
	localparam logic [7:0] EXTID_RESET = 8'h3c;
	localparam logic [7:0] UID_RESET = 8'ha5;
	localparam logic [31:0] PTR_RESET = 32'h0000_0000;
	// interrupt control/status field layout
	localparam int ICS_EN_BIT = 7;
	localparam int ICS_REQ_BIT = 6;
	localparam int ICS_LVL_LSB = 4;
	localparam int ICS_LVL_W = 2;
	// control register field layout
	localparam int CTRL_LVL_OVR_BIT = 7;
	localparam int CTRL_LVL_LSB = 4;
	localparam int CTRL_DMA_EN_BIT = 0;
	localparam int CTRL_EVT_BIT = 1;
	localparam int SC_W = 5;
	localparam logic [2:0] LVL_MIN = 3'h3;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] ICS_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam int WAIT_CYCLES = 1;

	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] addr;
		logic [31:0] wdata;
		logic [3:0] be;
	} eiocb_req_t;
endpackage

// ---- eiocb_slave.sv ----
`timescale 1ns/1ns
`default_nettype none
// Function
// - byte-wide data sits in the low, odd-addressed byte lane.
// - the data path is built as a 32-bit slave.
// - dma is optional and the last-transfer indication is sampled.
// - register accesses are answered while dma is enabled.
// - the slot base is decoded from five select-code switches.
// - the identification and interrupt control registers exist.
// - the uncached-space identification register exists.
// - a pointer to the uncached space sits at offset eight.
// - an extension identifier register is provided.
// - the interrupt is autovectored, never vectored.
// - switches choose interrupt level three through six.
// - control register bits may override the level by software.
// - levels outside three to six are never driven.
// - the card decodes only its own 64K slot; other slots get an error response.
// - the control, data and pointer registers read back what was written.
// - reads have no side effect.
module eiocb_slave (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [20:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic [1:0] avs_response_o,
	input wire logic [4:0] sel_code_i,
	input wire logic [1:0] irq_lvl_sw_i,
	input wire logic event_i,
	input wire logic dma_done_n_i,
	input wire logic dma_ack_i,
	output logic [3:0] irq_o,
	output logic dma_req_o,
	output logic dma_last_o
);
	// ----------------------------------------
	// request decode
	// ----------------------------------------
	eiocb_pkg::eiocb_req_t req;
	logic hit;
	logic fire;
	logic take;
	logic busy_r;
	logic wr_ctrl;
	logic wr_data;
	logic wr_ptr;
	logic wr_ics;
	logic ics_en_r;
	logic ics_cause_r;
	logic [1:0] ics_lvl_r;
	logic [7:0] ctrl_r;
	logic [31:0] ptr_r;
	logic [7:0] data_r;
	logic [31:0] rd_nxt;
	logic [2:0] lvl;
	logic [1:0] lvl_idx;

	// slot address bits 20:16 match the switches, 64K slot
	assign hit = (avs_address_i[20:16] == sel_code_i);

	always_comb begin
		req.read = avs_read_i & hit;
		req.write = avs_write_i & hit;
		req.addr = avs_address_i[9:2];
		req.wdata = avs_writedata_i;
		req.be = avs_byteenable_i;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// byte registers only see lane 0, the low odd-addressed byte
	function automatic logic [7:0] merge8(input logic [7:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		if (be[0]) begin
			merge8 = wd[7:0];
		end else begin
			merge8 = old;
		end
	endfunction

	// level 3..6 folded onto a two-bit line index
	function automatic logic [1:0] level_index(input logic [2:0] level);
		level_index = 2'(level - eiocb_pkg::LVL_MIN);
	endfunction

	// ----------------------------------------
	// handshake, one wait state
	// ----------------------------------------
	// answering never depends on dma state, so registers stay reachable
	assign fire = (avs_read_i | avs_write_i) & avs_waitrequest_o & ~busy_r;
	// the edge where the master sees waitrequest low
	assign take = busy_r & ~avs_waitrequest_o;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_r <= 1'b0;
		end else begin
			busy_r <= fire;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			avs_waitrequest_o <= 1'b1;
		end else begin
			avs_waitrequest_o <= ~fire;
		end
	end

	// ----------------------------------------
	// write strobes
	// ----------------------------------------
	// writes land only at the take edge, never on the first edge
	assign wr_ctrl = take & req.write & (req.addr == eiocb_pkg::REG_CTRL);
	assign wr_data = take & req.write & (req.addr == eiocb_pkg::REG_DATA);
	assign wr_ptr = take & req.write & (req.addr == eiocb_pkg::REG_PTR);
	assign wr_ics = take & req.write & (req.addr == eiocb_pkg::REG_ICS);

	// ----------------------------------------
	// writable registers
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_r <= eiocb_pkg::CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_r <= merge8(ctrl_r, req.wdata, req.be);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			data_r <= eiocb_pkg::DATA_RESET;
		end else if (wr_data) begin
			data_r <= merge8(data_r, req.wdata, req.be);
		end
	end

	// pointer is a full word; byte enables are not honoured here
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ptr_r <= eiocb_pkg::PTR_RESET;
		end else if (wr_ptr) begin
			ptr_r <= req.wdata;
		end
	end

	// ----------------------------------------
	// interrupt level
	// ----------------------------------------
	// level is always 3..6: two bits offset from the minimum
	always_comb begin
		if (ctrl_r[eiocb_pkg::CTRL_LVL_OVR_BIT]) begin
			lvl = eiocb_pkg::LVL_MIN + {1'b0,
				ctrl_r[eiocb_pkg::CTRL_LVL_LSB +: eiocb_pkg::ICS_LVL_W]};
		end else begin
			lvl = eiocb_pkg::LVL_MIN + {1'b0, irq_lvl_sw_i};
		end
		lvl_idx = level_index(lvl);
	end

	// ----------------------------------------
	// interrupt control and status
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ics_en_r <= eiocb_pkg::ICS_RESET[eiocb_pkg::ICS_EN_BIT];
		end else if (wr_ics && req.be[0]) begin
			ics_en_r <= req.wdata[eiocb_pkg::ICS_EN_BIT];
		end
	end

	// write one clears the cause; an event in the same cycle wins
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ics_cause_r <= eiocb_pkg::ICS_RESET[eiocb_pkg::ICS_REQ_BIT];
		end else if (event_i) begin
			ics_cause_r <= 1'b1;
		end else if (wr_ics && req.be[0]
			&& req.wdata[eiocb_pkg::ICS_REQ_BIT]) begin
			ics_cause_r <= 1'b0;
		end
	end

	// level field is read-only, it mirrors the live selection
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ics_lvl_r <= 2'h0;
		end else begin
			ics_lvl_r <= lvl_idx;
		end
	end

	// ----------------------------------------
	// request lines
	// ----------------------------------------
	// one-hot lines for levels 3..6; level 2 is never touched
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_o <= 4'h0;
		end else begin
			irq_o <= 4'h0;
			if (ics_en_r && ics_cause_r) begin
				irq_o[lvl_idx] <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// dma
	// ----------------------------------------
	// request stops once the last transfer has been seen
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dma_req_o <= 1'b0;
		end else if (ctrl_r[eiocb_pkg::CTRL_DMA_EN_BIT] && !dma_last_o) begin
			dma_req_o <= 1'b1;
		end else begin
			dma_req_o <= 1'b0;
		end
	end

	// sticky until software drops the enable
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dma_last_o <= 1'b0;
		end else if (!ctrl_r[eiocb_pkg::CTRL_DMA_EN_BIT]) begin
			dma_last_o <= 1'b0;
		end else if (dma_ack_i && !dma_done_n_i) begin
			dma_last_o <= 1'b1;
		end
	end

	// ----------------------------------------
	// read path, side-effect free
	// ----------------------------------------
	// pure mux: nothing here feeds back into any register
	always_comb begin
		rd_nxt = 32'h0000_0000;
		case (req.addr)
			eiocb_pkg::REG_ID: begin
				rd_nxt[7:0] = eiocb_pkg::ID_RESET;
			end
			eiocb_pkg::REG_ICS: begin
				rd_nxt[eiocb_pkg::ICS_EN_BIT] = ics_en_r;
				rd_nxt[eiocb_pkg::ICS_REQ_BIT] = ics_cause_r;
				rd_nxt[eiocb_pkg::ICS_LVL_LSB +: eiocb_pkg::ICS_LVL_W] = ics_lvl_r;
			end
			eiocb_pkg::REG_EXTID: begin
				rd_nxt[7:0] = eiocb_pkg::EXTID_RESET;
			end
			eiocb_pkg::REG_PTR: begin
				rd_nxt = ptr_r;
			end
			eiocb_pkg::REG_CTRL: begin
				rd_nxt[7:0] = ctrl_r;
			end
			eiocb_pkg::REG_DATA: begin
				rd_nxt[7:0] = data_r;
			end
			eiocb_pkg::REG_DMA: begin
				rd_nxt[1:0] = {dma_last_o, dma_req_o};
			end
			eiocb_pkg::REG_UID: begin
				rd_nxt[7:0] = eiocb_pkg::UID_RESET;
			end
			default: begin
				rd_nxt = 32'h0000_0000;
			end
		endcase
	end

	// ----------------------------------------
	// bus answer
	// ----------------------------------------
	// data stands from the fire edge until the next access
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (fire) begin
			if (req.read) begin
				avs_readdata_o <= rd_nxt;
			end else begin
				avs_readdata_o <= 32'h0000_0000;
			end
		end
	end

	// a foreign slot still gets an answer, so the bus never hangs
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			avs_response_o <= 2'h0;
		end else if (fire) begin
			avs_response_o <= hit ? 2'h0 : 2'h2;
		end
	end
endmodule
`default_nettype wire

// ---- eiocb_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module eiocb_sva (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [20:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic [1:0] avs_response_o,
	input wire logic [4:0] sel_code_i,
	input wire logic [3:0] irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	logic ans;
	logic hit;
	assign ans = !avs_waitrequest_o && avs_read_i;
	assign hit = avs_address_i[20:16] == sel_code_i;
	a_wait_one:
		assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low too long");
	a_wait_answer:
		assert property ($rose(avs_read_i || avs_write_i) |-> ##[1:2] !avs_waitrequest_o)
		else $error("no answer");
	a_slot_err:
		assert property (ans && !hit |-> avs_response_o == 2'h2 && avs_readdata_o == 32'h0)
		else $error("foreign slot answered");
	a_slot_ok:
		assert property (ans && hit |-> avs_response_o == 2'h0)
		else $error("own slot refused");
	a_id_value:
		assert property (ans && hit && avs_address_i[9:2] == eiocb_pkg::REG_ID
			|-> avs_readdata_o[7:0] == eiocb_pkg::ID_RESET) else $error("bad id");
	a_uid_value:
		assert property (ans && hit && avs_address_i[9:2] == eiocb_pkg::REG_UID
			|-> avs_readdata_o[7:0] == eiocb_pkg::UID_RESET) else $error("bad uid");
	a_irq_single:
		assert property ($onehot0(irq_o)) else $error("two levels driven");
	a_irq_hold:
		assert property (irq_o != 4'h0 && !avs_write_i && !$past(avs_write_i)
			|=> irq_o != 4'h0)
		else $error("request dropped without service");
endmodule
bind eiocb_slave eiocb_sva u_sva (
	.clk_i(clk_i),
	.rst_n_i(rst_n_i),
	.avs_address_i(avs_address_i),
	.avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i),
	.avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o),
	.avs_response_o(avs_response_o),
	.sel_code_i(sel_code_i),
	.irq_o(irq_o)
);
`default_nettype wire

// ---- eiocb_dma_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module eiocb_dma_host #(parameter int N = 3) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic req_i,
	output logic ack_o,
	output logic done_n_o
);
	int cnt_r;
	// slow controller: acks every other edge to stress the card
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_o <= 1'b0;
			done_n_o <= 1'b1;
			cnt_r <= 0;
		end else begin
			ack_o <= req_i && !ack_o;
			done_n_o <= !(req_i && !ack_o && cnt_r == N - 1);
			cnt_r <= cnt_r + 32'(req_i && !ack_o);
		end
	end
endmodule
`default_nettype wire

// ---- external_io_card_bus_slave_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module external_io_card_bus_slave_tb;
	localparam logic [4:0] SC = 5'h07;
	logic clk_i, rst_n_i, avs_read_i, avs_write_i, event_i, dma_done_n_i;
	logic dma_ack_i, dma_req_o, dma_last_o, avs_waitrequest_o;
	logic [20:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, rd;
	logic [3:0] avs_byteenable_i, irq_o;
	logic [1:0] avs_response_o, irq_lvl_sw_i, rsp;
	logic [4:0] sel_code_i;
	int miscompares, samples_checked;
	eiocb_slave dut (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o),
		.avs_response_o(avs_response_o),
		.sel_code_i(sel_code_i),
		.irq_lvl_sw_i(irq_lvl_sw_i),
		.event_i(event_i),
		.dma_done_n_i(dma_done_n_i),
		.dma_ack_i(dma_ack_i),
		.irq_o(irq_o),
		.dma_req_o(dma_req_o),
		.dma_last_o(dma_last_o)
	);
	eiocb_dma_host host (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(dma_req_o),
		.ack_o(dma_ack_i), .done_n_o(dma_done_n_i));
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	task automatic print_verdict();
		if (miscompares == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// one access; an idle edge follows so the next take is legal
	task automatic bus(input logic w, input logic [4:0] s, input logic [7:0] i,
		input logic [31:0] d);
		int n;
		n = 0;
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_address_i <= {s, 6'h00, i, 2'h0};
		avs_writedata_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 50);
		if (avs_waitrequest_o !== 1'b0) begin
			miscompares++;
			print_verdict();
		end
		rd = avs_readdata_o;
		rsp = avs_response_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rdchk(input logic [7:0] i, input logic [7:0] e);
		bus(1'b0, SC, i, 32'h0);
		chk(32'(rd[7:0]), 32'(e));
	endtask
	task automatic t_regs();
		rdchk(eiocb_pkg::REG_ID, eiocb_pkg::ID_RESET);
		rdchk(eiocb_pkg::REG_EXTID, eiocb_pkg::EXTID_RESET);
		rdchk(eiocb_pkg::REG_UID, eiocb_pkg::UID_RESET);
		bus(1'b1, SC, eiocb_pkg::REG_PTR, 32'h1234_5678);
		bus(1'b0, SC, eiocb_pkg::REG_PTR, 32'h0);
		chk(rd, 32'h1234_5678);
		bus(1'b1, SC, eiocb_pkg::REG_DATA, 32'ha5);
		rdchk(eiocb_pkg::REG_DATA, 8'ha5);
	endtask
	task automatic t_slot();
		bus(1'b1, SC ^ 5'h01, eiocb_pkg::REG_PTR, 32'h0);
		chk(32'(rsp), 32'h2);
		bus(1'b0, SC ^ 5'h10, eiocb_pkg::REG_ID, 32'h0);
		chk(rd, 32'h0);
		rdchk(eiocb_pkg::REG_PTR, 8'h78);
	endtask
	task automatic t_irq();
		for (int s = 0; s < 4; s++) begin
			irq_lvl_sw_i <= 2'(s);
			bus(1'b1, SC, eiocb_pkg::REG_ICS, 32'h80);
			event_i <= 1'b1;
			@(posedge clk_i);
			event_i <= 1'b0;
			repeat (3) @(posedge clk_i);
			chk(32'(irq_o), 32'h1 << s);
			bus(1'b0, SC, eiocb_pkg::REG_ICS, 32'h0);
			chk(32'(rd[7:4]), 32'hc | 32'(s));
			chk(32'(irq_o), 32'h1 << s);
			bus(1'b1, SC, eiocb_pkg::REG_ICS, 32'hc0);
			@(posedge clk_i);
			chk(32'(irq_o), 32'h0);
		end
	endtask
	task automatic t_ovr();
		bus(1'b1, SC, eiocb_pkg::REG_CTRL, 32'ha0);
		event_i <= 1'b1;
		@(posedge clk_i);
		event_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk(32'(irq_o), 32'h4);
		bus(1'b1, SC, eiocb_pkg::REG_ICS, 32'hc0);
		bus(1'b1, SC, eiocb_pkg::REG_CTRL, 32'h0);
	endtask
	task automatic t_dma();
		bus(1'b1, SC, eiocb_pkg::REG_CTRL, 32'h1);
		rdchk(eiocb_pkg::REG_CTRL, 8'h01);
		for (int n = 0; n < 200 && dma_last_o !== 1'b1; n++) @(posedge clk_i);
		chk(32'(dma_last_o), 32'h1);
		@(posedge clk_i);
		chk(32'(dma_req_o), 32'h0);
	endtask
	initial begin
		{rst_n_i, avs_read_i, avs_write_i, event_i} = 4'h0;
		avs_address_i = 21'h0;
		avs_writedata_i = 32'h0;
		avs_byteenable_i = 4'hf;
		irq_lvl_sw_i = 2'h0;
		sel_code_i = SC;
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		t_regs();
		t_slot();
		t_irq();
		t_ovr();
		t_dma();
		print_verdict();
	end
endmodule
`default_nettype wire
